/* File: hw/fpc_map.svh */
// register offsets, field positions and reset values of the fractional pll control block
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
`define FPC_OFS_CTRL     8'h00
`define FPC_OFS_REFDIV   8'h04
`define FPC_OFS_FBDIV    8'h08
`define FPC_OFS_NUM      8'h0c
`define FPC_OFS_DEN      8'h10
`define FPC_OFS_PUMP     8'h14
`define FPC_OFS_MON      8'h18
`define FPC_OFS_LOCK     8'h1c
`define FPC_OFS_DEVLO    8'h20
`define FPC_OFS_DEVHI    8'h24
`define FPC_OFS_PINS     8'h28
`define FPC_OFS_STATUS   8'h2c
`define FPC_CTRL_DOUBLER 0
`define FPC_CTRL_RESTR   1
`define FPC_CTRL_RCODE   2
`define FPC_CTRL_ORDER   4
`define FPC_CTRL_PHASE   7
`define FPC_CTRL_CSR     8
`define FPC_CTRL_TRIGPIN 10
`define FPC_CTRL_TRIGEN  12
`define FPC_CTRL_SWTRIG  13
`define FPC_PUMP_GAIN    0
`define FPC_PUMP_FLGAIN  8
`define FPC_PUMP_TOC     16
`define FPC_MON_LOW      0
`define FPC_MON_HIGH     8
`define FPC_LOCK_TOL     0
`define FPC_LOCK_DLY     8
`define FPC_LOCK_ERRC    16
`define FPC_LOCK_PASSC   24
`define FPC_RST_REFDIV   16'h0001
`define FPC_RST_FBDIV    16'h0010
`define FPC_RST_GAIN     5'h01
`define FPC_RST_FLGAIN   5'h1f
`define FPC_RST_LOW      6'h06
`define FPC_RST_HIGH     6'h2a
`define FPC_RST_TOL      6'h08
`define FPC_RST_ERRC     8'h04
`define FPC_RST_PASSC    8'h20
`define FPC_DEN_FULL     25'h1000000
`endif

/* File: hw/fpc_pkg.sv */
// types of the fractional pll control block
package fpc_pkg;
  typedef enum logic [2:0] {ORD_INT = 3'b000, ORD_1 = 3'b001, ORD_2 = 3'b010,
                            ORD_3 = 3'b011, ORD_4 = 3'b100} fpc_order_e;
  typedef enum logic [2:0] {PF_OFF = 3'b000, PF_DLD = 3'b001, PF_MON = 3'b010,
                            PF_BOTH = 3'b011, PF_FL = 3'b100, PF_SHIFT = 3'b101} fpc_pinfn_e;
  typedef struct packed {
    logic doubler; logic restricted; logic [1:0] rcode; logic [2:0] order;
    logic phase_sel; logic [1:0] csr; logic [1:0] trig_pin; logic trig_en;
    logic [15:0] ref_div; logic [15:0] n_div; logic [23:0] num; logic [23:0] den;
    logic [4:0] gain; logic [4:0] fl_gain; logic [15:0] fastlock_timeout_count;
    logic [5:0] low; logic [5:0] high; logic [5:0] tol; logic [1:0] dly;
    logic [7:0] errc; logic [7:0] passc; logic [32:0] dev; logic [15:0] pins;
    logic wr_pend; logic [7:0] waddr; logic sw_trig;
    logic [31:0] hrdata; logic hreadyout;
    logic ref_s1; logic ref_s2; logic ref_prev; logic fb_s1; logic fb_s2; logic fb_prev;
    logic [3:0] pin_s1; logic [3:0] pin_s2; logic [3:0] pin_prev;
    logic [15:0] ref_cnt; logic [1:0] csr_cnt; logic pd_tick;
    logic [2:0] pre_cnt; logic [1:0] swallow; logic [13:0] main_cnt; logic fb_tick;
    logic [15:0] n_cur; logic [3:0][23:0] acc; logic [3:0][5:0] dprev;
    logic [15:0] fl_cnt; logic fl_active;
    logic [7:0] pass_cnt; logic [7:0] err_cnt; logic locked; logic mon_ok;
    logic shift_on; logic psk_pend;
    logic [4:0] pump_gain; logic [3:0] pin_out; logic [3:0] pin_oe;
  } fpc_st_s;
endpackage

/* File: hw/fpc_ctrl.sv */
// digital control of a fractional-n synthesizer: dividers, modulator, fastlock, lock detect
`timescale 1ns/1ps
`include "fpc_map.svh"

// Overview of operation
// - reference divider is 16 bits, any divide 1 to 65535 when unrestricted
// - restricted mode limits reference divide to 2, 4, 8 or 16
// - 16-bit feedback divider built on 4/5 prescaler, steps by one
// - delta-sigma modulator of order one to four drives feedback divider
// - 24-bit denominator 1 to 2^24, forced to 2^24 while ramping
// - doubler counts both reference edges, doubling detector rate
// - fastlock only with nonzero timeout; feedback write starts it
// - fastlock pump gain replaces normal gain while timeout runs
// - cycle slip reduction divides detector rate by 2 or 4 during fastlock
// - inverted open-drain timeout pin floats normally, grounds during fastlock
// - detector-rate counters, fastlock timeout included, run at reduced rate
// - lock indication routable to any of four multipurpose pins
// - pump voltage compared against low and high threshold codes
// - each comparison is error when phase error plus delay exceeds tolerance
// - unlocked once error comparisons reach programmed error count
// - locked once passes reach pass count, which also clears errors
// - two-level shift keying on selected pin transition or software action
// - phase select chooses frequency shift or phase shift of deviation
// - deviation adds on top of ramp modulation
module fpc_ctrl (
  input  wire logic        sys_clk,           // 100 mhz system clock
  input  wire logic        nrst,              // async reset, active low
  input  wire logic        hsel,              // ahb slave select
  input  wire logic [7:0]  haddr,             // ahb byte address
  input  wire logic [1:0]  htrans,            // ahb transfer type
  input  wire logic        hwrite,            // ahb write
  input  wire logic [2:0]  hsize,             // ahb size, word only
  input  wire logic [31:0] hwdata,            // ahb write data
  input  wire logic        hready,            // ahb bus ready
  output logic      [31:0] hrdata,            // ahb read data
  output logic             hreadyout,         // ahb slave ready
  output logic             hresp,             // ahb response, always okay
  input  wire logic        reference_input,   // reference pin
  input  wire logic        feedback_input,    // vco feedback pin
  input  wire logic [3:0]  mp_pin_in,         // multipurpose pins, level seen
  output logic      [3:0]  mp_pin_out,        // multipurpose pins, driven value
  output logic      [3:0]  mp_pin_oe,         // multipurpose pins, drive enable
  input  wire logic [7:0]  phase_error,       // phase error magnitude at detector
  input  wire logic [5:0]  pump_voltage_code, // digitised pump voltage
  input  wire logic        ramp_running,      // ramp generator active
  input  wire logic [32:0] ramp_offset,       // ramp numerator offset, signed
  output logic      [4:0]  charge_pump_gain,  // gain to charge pump
  output logic             pd_tick,           // detector cycle pulse
  output logic             fb_tick,           // feedback divider cycle pulse
  output logic      [15:0] fb_divide          // divide value of current cycle
);
  fpc_pkg::fpc_st_s st;
  fpc_pkg::fpc_st_s nx;

  logic        ref_edge;
  logic [15:0] rdiv;
  logic        ref_tick;
  logic [1:0]  csr_last;
  logic        pd_now;
  logic [24:0] den_eff;
  logic        fb_edge;
  logic        pre_done;
  logic        fb_now;
  logic        fb_wr;
  logic        trigger;
  logic        err_cmp;

  function automatic logic pin_sig(input logic [2:0] fn, input fpc_pkg::fpc_st_s s);
    case (fn)
      fpc_pkg::PF_DLD:   pin_sig = s.locked;
      fpc_pkg::PF_MON:   pin_sig = s.mon_ok;
      fpc_pkg::PF_BOTH:  pin_sig = s.locked & s.mon_ok;
      fpc_pkg::PF_FL:    pin_sig = s.fl_active;
      fpc_pkg::PF_SHIFT: pin_sig = s.shift_on;
      default:           pin_sig = 1'b0;
    endcase
  endfunction

  assign ref_edge = st.doubler ? (st.ref_s2 ^ st.ref_prev)
                               : (st.ref_s2 & ~st.ref_prev);
  assign rdiv     = st.restricted ? (16'h0002 << st.rcode)
                                  : ((st.ref_div == 16'h0) ? 16'h0001 : st.ref_div);
  assign ref_tick = ref_edge && (st.ref_cnt >= rdiv - 16'h0001);
  assign csr_last = !st.fl_active ? 2'h0 :
                    (st.csr == 2'h1) ? 2'h1 : (st.csr == 2'h2) ? 2'h3 : 2'h0;
  assign pd_now   = ref_tick && (st.csr_cnt >= csr_last);
  assign den_eff  = (ramp_running || st.den == 24'h0) ? `FPC_DEN_FULL
                                                      : {1'b0, st.den};
  assign fb_edge  = st.fb_s2 & ~st.fb_prev;
  assign pre_done = fb_edge && (st.pre_cnt >= ((st.swallow != 2'h0) ? 3'h4 : 3'h3));
  assign fb_now   = pre_done && ({2'h0, st.main_cnt} >= {2'h0, st.n_cur[15:2]} - 16'h0001);
  assign fb_wr    = st.wr_pend && (st.waddr == `FPC_OFS_FBDIV);
  assign trigger  = st.trig_en ? (st.pin_s2[st.trig_pin] ^ st.pin_prev[st.trig_pin])
                               : st.sw_trig;
  assign err_cmp  = ({1'b0, phase_error} + {7'h0, st.dly}) > {3'h0, st.tol};
  always_comb
  begin
    logic signed [34:0] inc;
    logic signed [34:0] sum;
    logic signed [34:0] den_s;
    logic signed [34:0] dev_s;
    logic signed [1:0]  c [4];
    logic signed [5:0]  d [4];
    logic [7:0]         a;
    logic [3:0]         sel;
    inc   = '0;
    sum   = '0;
    den_s = $signed({10'h0, den_eff});
    dev_s = $signed({{2{st.dev[32]}}, st.dev});
    c     = '{default: '0};
    d     = '{default: '0};
    a     = st.waddr;
    sel   = '0;
    nx    = st;
    // bus: zero wait states, read data registered in the address phase
    nx.hreadyout = 1'b1;
    nx.wr_pend   = 1'b0;
    nx.sw_trig   = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      nx.wr_pend = hwrite;
      nx.waddr   = haddr;
      if (!hwrite)
      begin
        if (haddr == `FPC_OFS_CTRL)
          nx.hrdata = {19'h0, st.trig_en, st.trig_pin, st.csr, st.phase_sel, st.order,
                       st.rcode, st.restricted, st.doubler};
        else if (haddr == `FPC_OFS_REFDIV)
          nx.hrdata = {16'h0, st.ref_div};
        else if (haddr == `FPC_OFS_FBDIV)
          nx.hrdata = {16'h0, st.n_div};
        else if (haddr == `FPC_OFS_NUM)
          nx.hrdata = {8'h0, st.num};
        else if (haddr == `FPC_OFS_DEN)
          nx.hrdata = {8'h0, st.den};
        else if (haddr == `FPC_OFS_PUMP)
          nx.hrdata = {st.fastlock_timeout_count, 3'h0, st.fl_gain, 3'h0, st.gain};
        else if (haddr == `FPC_OFS_MON)
          nx.hrdata = {18'h0, st.high, 2'h0, st.low};
        else if (haddr == `FPC_OFS_LOCK)
          nx.hrdata = {st.passc, st.errc, 6'h0, st.dly, 2'h0, st.tol};
        else if (haddr == `FPC_OFS_DEVLO)
          nx.hrdata = st.dev[31:0];
        else if (haddr == `FPC_OFS_DEVHI)
          nx.hrdata = {31'h0, st.dev[32]};
        else if (haddr == `FPC_OFS_PINS)
          nx.hrdata = {16'h0, st.pins};
        else if (haddr == `FPC_OFS_STATUS)
          nx.hrdata = {26'h0, st.psk_pend, st.shift_on, st.fl_active, st.mon_ok, 1'b0,
                       st.locked};
        else
          nx.hrdata = 32'h0;
      end
    end
    if (st.wr_pend)
    begin
      if (a == `FPC_OFS_CTRL)
      begin
        nx.doubler    = hwdata[`FPC_CTRL_DOUBLER];
        nx.restricted = hwdata[`FPC_CTRL_RESTR];
        nx.rcode      = hwdata[`FPC_CTRL_RCODE +: 2];
        nx.order      = hwdata[`FPC_CTRL_ORDER +: 3];
        nx.phase_sel  = hwdata[`FPC_CTRL_PHASE];
        nx.csr        = hwdata[`FPC_CTRL_CSR +: 2];
        nx.trig_pin   = hwdata[`FPC_CTRL_TRIGPIN +: 2];
        nx.trig_en    = hwdata[`FPC_CTRL_TRIGEN];
        nx.sw_trig    = hwdata[`FPC_CTRL_SWTRIG];
      end
      else if (a == `FPC_OFS_REFDIV)
        nx.ref_div = hwdata[15:0];
      else if (a == `FPC_OFS_FBDIV)
        nx.n_div = hwdata[15:0];
      else if (a == `FPC_OFS_NUM)
        nx.num = hwdata[23:0];
      else if (a == `FPC_OFS_DEN)
        nx.den = hwdata[23:0];
      else if (a == `FPC_OFS_PUMP)
      begin
        nx.gain    = hwdata[`FPC_PUMP_GAIN +: 5];
        nx.fl_gain = hwdata[`FPC_PUMP_FLGAIN +: 5];
        nx.fastlock_timeout_count  = hwdata[`FPC_PUMP_TOC +: 16];
      end
      else if (a == `FPC_OFS_MON)
      begin
        nx.low  = hwdata[`FPC_MON_LOW +: 6];
        nx.high = hwdata[`FPC_MON_HIGH +: 6];
      end
      else if (a == `FPC_OFS_LOCK)
      begin
        nx.tol   = hwdata[`FPC_LOCK_TOL +: 6];
        nx.dly   = hwdata[`FPC_LOCK_DLY +: 2];
        nx.errc  = hwdata[`FPC_LOCK_ERRC +: 8];
        nx.passc = hwdata[`FPC_LOCK_PASSC +: 8];
      end
      else if (a == `FPC_OFS_DEVLO)
        nx.dev[31:0] = hwdata;
      else if (a == `FPC_OFS_DEVHI)
        nx.dev[32] = hwdata[0];
      else if (a == `FPC_OFS_PINS)
        nx.pins = hwdata[15:0];
    end
    // pin synchronisers
    nx.ref_s1   = reference_input;
    nx.ref_s2   = st.ref_s1;
    nx.ref_prev = st.ref_s2;
    nx.fb_s1    = feedback_input;
    nx.fb_s2    = st.fb_s1;
    nx.fb_prev  = st.fb_s2;
    nx.pin_s1   = mp_pin_in;
    nx.pin_s2   = st.pin_s1;
    nx.pin_prev = st.pin_s2;
    // reference divider and slip reduction prescale
    if (ref_tick)
    begin
      nx.ref_cnt = 16'h0;
      nx.csr_cnt = pd_now ? 2'h0 : st.csr_cnt + 2'h1;
    end
    else if (ref_edge)
      nx.ref_cnt = st.ref_cnt + 16'h0001;
    nx.pd_tick = pd_now;
    // feedback divider: n = 4p + s, s prescaler cycles stretched to five
    nx.fb_tick = fb_now;
    if (pre_done)
    begin
      nx.pre_cnt = 3'h0;
      if (st.swallow != 2'h0)
        nx.swallow = st.swallow - 2'h1;
      nx.main_cnt = fb_now ? 14'h0 : st.main_cnt + 14'h0001;
    end
    else if (fb_edge)
      nx.pre_cnt = st.pre_cnt + 3'h1;
    // mash modulator stepped once per feedback cycle
    if (fb_now)
    begin
      inc = $signed({11'h0, st.num}) + $signed({{2{ramp_offset[32]}}, ramp_offset});
      if (!st.phase_sel && st.shift_on)
        inc = inc + dev_s;
      if (st.phase_sel && st.psk_pend)
        inc = st.shift_on ? inc + dev_s : inc - dev_s;
      nx.psk_pend = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
        if (k > 0)
          inc = $signed({11'h0, nx.acc[k-1]});
        if (k < int'(st.order))
        begin
          sum = $signed({11'h0, st.acc[k]}) + inc;
          if (sum >= den_s)
          begin
            sum  = sum - den_s;
            c[k] = 2'sd1;
          end
          else if (sum < 0)
          begin
            sum  = sum + den_s;
            c[k] = -2'sd1;
          end
          nx.acc[k] = sum[23:0];
        end
      end
      d[3] = 6'(c[3]);
      for (int k = 2; k >= 0; k--)
        d[k] = 6'(c[k]) + d[k+1] - st.dprev[k+1];
      for (int k = 0; k < 4; k++)
        nx.dprev[k] = d[k];
      nx.n_cur   = st.n_div + {{10{d[0][5]}}, d[0]};
      nx.swallow = nx.n_cur[1:0];
    end
    // shift keying: a trigger flips the level; phase mode steps once
    if (trigger)
    begin
      nx.shift_on = !st.shift_on;
      nx.psk_pend = st.phase_sel;
    end
    // fastlock timeout, clocked at the reduced detector rate
    if (fb_wr)
    begin
      nx.fl_active = (st.fastlock_timeout_count != 16'h0);
      nx.fl_cnt    = st.fastlock_timeout_count;
    end
    else if (pd_now && st.fl_active)
    begin
      nx.fl_cnt = st.fl_cnt - 16'h0001;
      if (st.fl_cnt <= 16'h0001)
        nx.fl_active = 1'b0;
    end
    nx.pump_gain = st.fl_active ? st.fl_gain : st.gain;
    // digital lock detect
    if (pd_now)
    begin
      if (err_cmp)
      begin
        if (st.err_cnt + 8'h01 >= st.errc)
        begin
          nx.locked   = 1'b0;
          nx.err_cnt  = 8'h0;
          nx.pass_cnt = 8'h0;
        end
        else
          nx.err_cnt = st.err_cnt + 8'h01;
      end
      else if (st.pass_cnt + 8'h01 >= st.passc)
      begin
        nx.locked   = 1'b1;
        nx.pass_cnt = 8'h0;
        nx.err_cnt  = 8'h0;
      end
      else
        nx.pass_cnt = st.pass_cnt + 8'h01;
    end
    nx.mon_ok = (pump_voltage_code >= st.low) && (pump_voltage_code <= st.high);
    // pins: bit 3 of each nibble selects inverted open drain
    for (int i = 0; i < 4; i++)
    begin
      sel = st.pins[4*i +: 4];
      if (sel[3])
      begin
        nx.pin_oe[i]  = pin_sig(sel[2:0], st);
        nx.pin_out[i] = 1'b0;
      end
      else
      begin
        nx.pin_oe[i]  = (sel[2:0] != 3'h0);
        nx.pin_out[i] = pin_sig(sel[2:0], st);
      end
    end
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st         <= '0;
      st.ref_div <= `FPC_RST_REFDIV;
      st.n_div   <= `FPC_RST_FBDIV;
      st.n_cur   <= `FPC_RST_FBDIV;
      st.gain    <= `FPC_RST_GAIN;
      st.fl_gain <= `FPC_RST_FLGAIN;
      st.low     <= `FPC_RST_LOW;
      st.high    <= `FPC_RST_HIGH;
      st.tol     <= `FPC_RST_TOL;
      st.errc    <= `FPC_RST_ERRC;
      st.passc   <= `FPC_RST_PASSC;
    end
    else
      st <= nx;
  end
  assign hrdata           = st.hrdata;
  assign hreadyout        = st.hreadyout;
  assign hresp            = 1'b0;
  assign mp_pin_out       = st.pin_out;
  assign mp_pin_oe        = st.pin_oe;
  assign charge_pump_gain = st.pump_gain;
  assign pd_tick          = st.pd_tick;
  assign fb_tick          = st.fb_tick;
  assign fb_divide        = st.n_cur;
  sequence fl_write_s;
    fb_wr && st.fastlock_timeout_count != 16'h0;
  endsequence
  sequence fl_expire_s;
    pd_now && st.fl_active && st.fl_cnt == 16'h0001 && !fb_wr;
  endsequence
  fl_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fl_write_s |=> st.fl_active && st.fl_cnt == $past(st.fastlock_timeout_count))
    else $error("fastlock did not start on feedback write");
  fl_gain_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fl_write_s |=> ##1 charge_pump_gain == $past(st.fl_gain, 2))
    else $error("fastlock gain not applied");
  fl_end_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fl_expire_s |=> !st.fl_active ##1 charge_pump_gain == $past(st.gain))
    else $error("fastlock did not end at timeout");
  csr_rate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pd_now && st.fl_active && st.csr == 2'h2 |=> (!pd_now || !st.fl_active)[*5])
    else $error("detector rate not reduced");
  ref_restr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ref_tick && st.restricted |-> st.ref_cnt == (16'h0002 << st.rcode) - 16'h0001)
    else $error("restricted reference divide wrong");
  den_force_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ramp_running |-> den_eff == `FPC_DEN_FULL)
    else $error("denominator not forced while ramping");
  lock_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pd_now && !err_cmp && st.pass_cnt + 8'h01 >= st.passc |=> st.locked && st.err_cnt == 8'h0)
    else $error("lock not declared at pass count");
  lock_clr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pd_now && err_cmp && st.err_cnt + 8'h01 >= st.errc |=> !st.locked ##1 !st.locked || pd_now)
    else $error("unlock not declared at error count");
  od_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    st.pins[3:0] == 4'hc && $stable(st.pins) |=> mp_pin_oe[0] == $past(st.fl_active) && !mp_pin_out[0])
    else $error("timeout pin state wrong");
  shift_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    trigger |=> st.shift_on != $past(st.shift_on))
    else $error("shift keying trigger ignored");
  mon_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pump_voltage_code < st.low && $stable(st.low) |=> !st.mon_ok)
    else $error("pump monitor low threshold ignored");
endmodule // fpc_ctrl

/* File: verif/fpc_vco_model.sv */
// behavioural vco and loop filter facing the synthesizer control block
`timescale 1ns/1ps
module fpc_vco_model (
  input  wire logic       sys_clk,           // system clock
  input  wire logic [4:0] charge_pump_gain,  // pump gain driving the filter
  input  wire logic       big_err,           // bench asks for a wide phase error
  input  wire logic [5:0] code_in,           // loop voltage code to present
  output logic            feedback_input,    // divided vco output
  output logic      [7:0] phase_error,       // phase error magnitude
  output logic      [5:0] pump_voltage_code  // digitised loop voltage
);
  logic [1:0] ph = 2'h0;
  always @(posedge sys_clk)
  begin
    ph <= ph + 2'h1;
    feedback_input <= ph[1];
    // a wider loop settles closer, so high gain gives a smaller residue
    phase_error <= big_err ? 8'hc8 : ((charge_pump_gain > 5'h08) ? 8'h01 : 8'h03);
    pump_voltage_code <= code_in;
  end
endmodule // fpc_vco_model

/* File: verif/fpc_ctrl_tb.sv */
// self-checking bench of the fractional pll control block
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_ctrl_tb;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, ref_in, fb_in, big_err;
  logic pd_tick, fb_tick;
  logic        ramp_run;
  logic [32:0] ramp_off;
  logic [7:0]  haddr, pe;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  logic [3:0]  mp_pin_in, mp_pin_out, mp_pin_oe, pin_drv;
  logic [5:0]  pvc, code_in;
  logic [4:0]  gain;
  logic [15:0] fb_divide;
  int          n_errors, tests_run;
  logic [7:0]  ra [7] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
  logic [31:0] rv [7] = '{32'h1, 32'h10, 32'h0, 32'h1f01, 32'h2a06, 32'h20040008, 32'h0};
  logic [5:0]  mc [4] = '{6'h05, 6'h06, 6'h2a, 6'h2b};
  logic        me [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  // unselected pins are pulled up
  assign mp_pin_in = (mp_pin_oe & mp_pin_out) | (~mp_pin_oe & pin_drv);
  fpc_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reference_input(ref_in),
    .feedback_input(fb_in), .mp_pin_in(mp_pin_in), .mp_pin_out(mp_pin_out),
    .mp_pin_oe(mp_pin_oe), .phase_error(pe), .pump_voltage_code(pvc),
    .ramp_running(ramp_run), .ramp_offset(ramp_off), .charge_pump_gain(gain),
    .pd_tick(pd_tick), .fb_tick(fb_tick), .fb_divide(fb_divide));
  fpc_vco_model vco (.sys_clk(sys_clk), .charge_pump_gain(gain), .big_err(big_err),
    .code_in(code_in), .feedback_input(fb_in), .phase_error(pe), .pump_voltage_code(pvc));
  always #5 sys_clk = ~sys_clk;
  // reference period is eight system clocks, its edges fixed midway between rising clock edges
  always #40 ref_in = ~ref_in;
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // poll status until the masked bits settle; a stuck bit fails here
  task automatic stat(input string nm, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    for (int i = 0; i < 60; i++)
    begin
      bus(1'b0, `FPC_OFS_STATUS, 32'h0, q);
      if ((q & m) === e) break;
    end
    chk(nm, e, q & m);
  endtask
  task automatic gap(output logic [31:0] n);
    n = 0;
    repeat (2) do @(posedge sys_clk); while (pd_tick !== 1'b1);
    do begin @(posedge sys_clk); n++; end while (pd_tick !== 1'b1);
  endtask
  task automatic fgap(output logic [31:0] n);
    n = 0;
    repeat (2) do @(posedge sys_clk); while (fb_tick !== 1'b1);
    do begin @(posedge sys_clk); n++; end while (fb_tick !== 1'b1);
  endtask
  // sum of two successive divide values, each taken as its feedback cycle starts
  task automatic pair(output logic [31:0] s);
    repeat (2) do @(posedge sys_clk); while (fb_tick !== 1'b1);
    s = {16'h0, fb_divide};
    do @(posedge sys_clk); while (fb_tick !== 1'b1);
    s = s + {16'h0, fb_divide};
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_errors++;
    report_and_stop;
  end
  initial
  begin
    logic [31:0] q;
    int n;
    sys_clk = 0; ref_in = 0; nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hwdata = 0; pin_drv = 4'hf; big_err = 0; code_in = 6'h14; n_errors = 0; tests_run = 0;
    ramp_run = 0; ramp_off = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0, q);
      chk("reset value", rv[i], q);
    end
    for (int i = 0; i < 4; i++)
    begin
      code_in <= mc[i];
      stat("monitor ok", 32'h4, {29'h0, me[i], 2'h0});
    end
    // the lock pin is wired to lock and monitor together, so keep the monitor in range
    code_in <= 6'h14;
    wr(`FPC_OFS_REFDIV, 32'h3);
    gap(q); chk("gap div3", 32'd24, q);
    wr(`FPC_OFS_CTRL, 32'h6);
    gap(q); chk("gap restricted", 32'd32, q);
    wr(`FPC_OFS_CTRL, 32'h1); wr(`FPC_OFS_REFDIV, 32'h2);
    gap(q); chk("gap doubler", 32'd8, q);
    wr(`FPC_OFS_CTRL, 32'h0); wr(`FPC_OFS_REFDIV, 32'h1);
    wr(`FPC_OFS_PINS, 32'hb00c); wr(`FPC_OFS_PUMP, 32'h00031f02);
    wr(`FPC_OFS_FBDIV, 32'd20);
    repeat (2) @(posedge sys_clk);
    chk("fastlock gain", 32'd31, gain);
    chk("timeout pin", 32'h1, {mp_pin_oe[0], mp_pin_out[0]} == 2'b10);
    n = 0;
    while (gain !== 5'd2 && n < 200) begin @(posedge sys_clk); n++; end
    chk("fastlock span", 32'h1, n >= 16 && n <= 40);
    chk("pin released", 32'h0, mp_pin_oe[0]);
    fgap(q); chk("gap fb20", 32'd80, q);
    chk("divide in use", 32'd20, fb_divide);
    wr(`FPC_OFS_PUMP, 32'h1f02); wr(`FPC_OFS_FBDIV, 32'd21);
    repeat (3) @(posedge sys_clk);
    chk("no fastlock", 32'd2, gain);
    fgap(q); chk("gap fb21", 32'd84, q);
    wr(`FPC_OFS_LOCK, 32'h04020008);
    stat("locked", 32'h1, 32'h1);
    chk("lock pin", 32'h1, mp_pin_oe[3]);
    big_err <= 1'b1;
    stat("unlocked", 32'h1, 32'h0);
    chk("unlock pin", 32'h0, mp_pin_oe[3]);
    big_err <= 1'b0;
    wr(`FPC_OFS_DEVLO, 32'hffff_f000); wr(`FPC_OFS_DEVHI, 32'h1);
    wr(`FPC_OFS_CTRL, 32'h2000);
    stat("soft shift", 32'h10, 32'h10);
    wr(`FPC_OFS_CTRL, 32'h1400);
    pin_drv[1] <= 1'b0;
    stat("pin shift", 32'h10, 32'h0);
    wr(`FPC_OFS_CTRL, 32'h100); wr(`FPC_OFS_PUMP, 32'h00c81f02); wr(`FPC_OFS_FBDIV, 32'd20);
    gap(q); chk("gap slip", 32'd16, q);
    wr(`FPC_OFS_CTRL, 32'h200); wr(`FPC_OFS_FBDIV, 32'd20);
    gap(q); chk("gap slip4", 32'd32, q);
    wr(`FPC_OFS_NUM, 32'h1); wr(`FPC_OFS_DEN, 32'h2); wr(`FPC_OFS_CTRL, 32'h10);
    pair(q); chk("mash pair", 32'd41, q);
    ramp_run <= 1'b1;
    pair(q); chk("ramp den", 32'd40, q);
    ramp_off <= 33'h7fffff;
    pair(q); chk("ramp offset", 32'd41, q);
    report_and_stop;
  end
endmodule // fpc_ctrl_tb
